// ==== logic/rstm_pkg.sv ====
`default_nettype none
package rstm_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_TOP_FLAGS = 8'h1a;
    localparam logic [7:0] OFS_SD_FLAGS = 8'h1b;
    localparam logic [7:0] OFS_LR_FLAGS = 8'h1c;
    localparam logic [7:0] OFS_TOP_LIVE = 8'h1d;
    localparam logic [7:0] OFS_SD_STATUS = 8'h1e;
    localparam logic [7:0] OFS_LR_STATUS = 8'h1f;
    localparam logic [7:0] OFS_TOP_MASKS = 8'h20;

    // ------------------------------------------------------------------
    // Field positions of the rail status registers; rail flag registers use only the INV and LIM ones
    // ------------------------------------------------------------------
    localparam int RAIL1_ON_BIT = 7;
    localparam int RAIL1_INV_BIT = 6;
    localparam int RAIL1_LIM_BIT = 4;
    localparam int RAIL0_ON_BIT = 3;
    localparam int RAIL0_INV_BIT = 2;
    localparam int RAIL0_LIM_BIT = 0;

    // ------------------------------------------------------------------
    // Device level sources, same positions in masks, flags and live bits
    // ------------------------------------------------------------------
    localparam int POWER_OK_BIT = 7;
    localparam int SYNC_CLK_BIT = 4;
    localparam int THERMAL_BIT = 2;
    localparam int LOAD_MEAS_BIT = 0;

    // Implemented bits of each register; all others read as zero.
    localparam logic [7:0] RAIL_STATUS_BITS = 8'hdd;
    localparam logic [7:0] RAIL_FLAG_BITS = 8'h55;
    // Validity flags take either edge; limit flags only the rising one.
    localparam logic [7:0] RAIL_INV_BITS = 8'h44;
    localparam logic [7:0] TOP_SRC_BITS = 8'h95;
    localparam logic [7:0] TOP_LIVE_BITS = 8'h94;

    // Values after reset.
    localparam logic [7:0] TOP_MASKS_RESET = 8'h90;
    localparam logic [7:0] ZERO_RESET = 8'h00;

    // Serial port: seven-bit device address and index of the last bit in a byte.
    localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h60;
    localparam logic [2:0] LAST_BIT = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK,
        ST_RXB,
        ST_TXB,
        ST_RXACK
    } rstm_state_t;

endpackage : rstm_pkg
`default_nettype wire

// ==== logic/rstm_regs.sv ====
`timescale 1ns/100ps
`default_nettype none

// Operation
// (R1) Step-down converter enable states read at bits 7 and 3, 1 enabled.
// (R2) Step-down raw output validity reads at bits 6 and 2, 1 invalid.
// (R3) Step-down raw current limit reads at bits 4 and 0, 1 active.
// (R4) Linear regulator enable states read at bits 7 and 3, 1 enabled.
// (R5) Linear regulator raw output validity reads at bits 6 and 2, 1 invalid.
// (R6) Linear regulator raw current limit reads at bits 4 and 0, 1 active.
// (R7) A mask bit of 0 lets its interrupt happen and 1 blocks it.
// (R8) The power-good mask is bit 7 of the top mask register, reset 1.
// (R9) Masks only block interrupts and never touch the live status bits.
// (R10) The sync clock mask is bit 4 of the top mask register, reset 1.
// (R11) The thermal warning mask is bit 2 of the top mask register, reset 0.
// (R12) The load measurement mask is bit 0 of the top mask register, reset 0.
// (R13) Per-rail flags latch on their event and clear when written with 1.
// (R14) The live thermal warning bit reads 1 above the warning level.
// (R15) Reserved bits read zero and writes to status registers do nothing.
// (R16) Raw status follows its inputs every cycle and reads have no effect.
module rstm_regs #(
    parameter logic [6:0] DEV_ADDR = rstm_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic stepdown0_on,
    input wire logic stepdown1_on,
    input wire logic stepdown0_vout_invalid,
    input wire logic stepdown1_vout_invalid,
    input wire logic stepdown0_limit_active,
    input wire logic stepdown1_limit_active,
    input wire logic linreg0_on,
    input wire logic linreg1_on,
    input wire logic linreg0_vout_invalid,
    input wire logic linreg1_vout_invalid,
    input wire logic linreg0_limit_active,
    input wire logic linreg1_limit_active,
    input wire logic power_ok_pin,
    input wire logic ext_sync_clock_invalid,
    input wire logic thermal_warn_in,
    input wire logic load_meas_ready,
    output logic irq_out
);
    import rstm_pkg::*;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] sd_status_reg;
    logic [7:0] lr_status_reg;
    logic [7:0] top_live_reg;
    logic [7:0] top_masks_reg;
    logic [7:0] top_flags_reg;
    logic [7:0] sd_flags_reg;
    logic [7:0] lr_flags_reg;
    logic irq_reg;
    logic [7:0] sd_status_next;
    logic [7:0] lr_status_next;
    logic [7:0] top_live_next;
    logic [7:0] top_flags_next;
    logic [7:0] sd_flags_next;
    logic [7:0] lr_flags_next;
    logic [7:0] top_masks_next;

    // ------------------------------------------------------------------
    // Serial port state
    // ------------------------------------------------------------------
    rstm_state_t st_reg;
    rstm_state_t st_next;
    logic scl_q_reg;
    logic sda_q_reg;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic got_byte_reg;
    logic got_byte_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    logic rw_reg;
    logic rw_next;
    logic have_ptr_reg;
    logic have_ptr_next;
    logic addr_ack_reg;
    logic addr_ack_next;
    logic oe_reg;
    logic oe_next;

    // Raw inputs packed into their register layout, rebuilt every cycle.
    assign sd_status_next = {stepdown1_on, stepdown1_vout_invalid, 1'b0,
        stepdown1_limit_active, stepdown0_on, stepdown0_vout_invalid,
        1'b0, stepdown0_limit_active}; // [R1] [R2] [R3] [R15]
    assign lr_status_next = {linreg1_on, linreg1_vout_invalid, 1'b0,
        linreg1_limit_active, linreg0_on, linreg0_vout_invalid,
        1'b0, linreg0_limit_active}; // [R4] [R5] [R6] [R15]
    assign top_live_next = {power_ok_pin, 2'b00, ext_sync_clock_invalid,
        1'b0, thermal_warn_in, 2'b00}; // [R14]

    // Bus condition detection on the synchronous pin samples.
    wire scl_rise = scl_in & ~scl_q_reg;
    wire scl_fall = ~scl_in & scl_q_reg;
    wire bus_start = scl_in & scl_q_reg & sda_q_reg & ~sda_in;
    wire bus_stop = scl_in & scl_q_reg & ~sda_q_reg & sda_in;
    wire byte_end = scl_fall & got_byte_reg;
    wire addr_hit = shift_reg[7:1] == DEV_ADDR;

    // A write strobe fires once per data byte after the pointer byte.
    wire wr_stb = (st_reg == ST_RXB) & byte_end & have_ptr_reg;
    wire [7:0] wr_clr = wr_stb ? shift_reg : ZERO_RESET;
    wire wr_masks = wr_stb & (ptr_reg == OFS_TOP_MASKS);
    wire wr_top_fl = wr_stb & (ptr_reg == OFS_TOP_FLAGS);
    wire wr_sd_fl = wr_stb & (ptr_reg == OFS_SD_FLAGS);
    wire wr_lr_fl = wr_stb & (ptr_reg == OFS_LR_FLAGS);

    // Event detection against the previous raw samples, except load_meas_ready, which is an event in every cycle it is high.
    wire [7:0] sd_change = sd_status_next ^ sd_status_reg;
    wire [7:0] lr_change = lr_status_next ^ lr_status_reg;
    wire [7:0] sd_events = ((sd_change & sd_status_next) |
        (sd_change & RAIL_INV_BITS)) & RAIL_FLAG_BITS;
    wire [7:0] lr_events = ((lr_change & lr_status_next) |
        (lr_change & RAIL_INV_BITS)) & RAIL_FLAG_BITS;
    wire [7:0] top_events = {top_live_next[POWER_OK_BIT] ^
        top_live_reg[POWER_OK_BIT], 2'b00,
        top_live_next[SYNC_CLK_BIT] & ~top_live_reg[SYNC_CLK_BIT], 1'b0,
        top_live_next[THERMAL_BIT] & ~top_live_reg[THERMAL_BIT], 1'b0,
        load_meas_ready};

    // Flags: a new event wins over a write-1 clear in the same cycle.
    // Masks only stop a top flag from being set; live bits stay raw.
    assign top_flags_next = (top_flags_reg &
        ~(wr_top_fl ? wr_clr : ZERO_RESET)) |
        (top_events & ~top_masks_reg & TOP_SRC_BITS); // [R7] [R9]
    assign sd_flags_next = (sd_flags_reg &
        ~(wr_sd_fl ? wr_clr : ZERO_RESET)) | sd_events; // [R13]
    assign lr_flags_next = (lr_flags_reg &
        ~(wr_lr_fl ? wr_clr : ZERO_RESET)) | lr_events; // [R13]
    assign top_masks_next = wr_masks ? (shift_reg & TOP_SRC_BITS)
        : top_masks_reg; // [R8] [R10] [R11] [R12] [R15]

    // Read selection; status registers ignore writes, reads change nothing.
    wire [7:0] rd_data =
        (ptr_reg == OFS_SD_STATUS) ? sd_status_reg :
        (ptr_reg == OFS_LR_STATUS) ? lr_status_reg :
        (ptr_reg == OFS_TOP_LIVE) ? top_live_reg :
        (ptr_reg == OFS_TOP_MASKS) ? top_masks_reg :
        (ptr_reg == OFS_TOP_FLAGS) ? top_flags_reg :
        (ptr_reg == OFS_SD_FLAGS) ? sd_flags_reg :
        (ptr_reg == OFS_LR_FLAGS) ? lr_flags_reg : ZERO_RESET; // [R15] [R16]

    // ------------------------------------------------------------------
    // Serial port sequencer
    // ------------------------------------------------------------------
    // Receive bits on SCL rising, change SDA only on SCL falling so the
    // data line never moves while the clock is high.
    always_comb begin
        st_next = st_reg;
        shift_next = shift_reg;
        cnt_next = cnt_reg;
        got_byte_next = got_byte_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        have_ptr_next = have_ptr_reg;
        addr_ack_next = addr_ack_reg;
        oe_next = oe_reg;
        case (st_reg)
            ST_ADDR, ST_RXB: begin
                if (scl_rise) begin
                    shift_next = {shift_reg[6:0], sda_in};
                    cnt_next = cnt_reg + 3'h1;
                    got_byte_next = (cnt_reg == LAST_BIT);
                end else if (byte_end) begin
                    got_byte_next = 1'b0;
                    st_next = ST_ACK;
                    oe_next = 1'b1;
                    if (st_reg == ST_ADDR) begin
                        addr_ack_next = 1'b1;
                        rw_next = shift_reg[0];
                        if (!addr_hit) begin
                            st_next = ST_IDLE;
                            oe_next = 1'b0;
                        end
                    end else begin
                        addr_ack_next = 1'b0;
                        have_ptr_next = 1'b1;
                        ptr_next = have_ptr_reg ? ptr_reg + 8'h01
                            : shift_reg;
                    end
                end
            end
            ST_ACK: begin
                if (scl_fall) begin
                    cnt_next = 3'h0;
                    if (addr_ack_reg & rw_reg) begin
                        st_next = ST_TXB;
                        shift_next = rd_data;
                        oe_next = ~rd_data[7];
                    end else begin
                        st_next = ST_RXB;
                        oe_next = 1'b0;
                        if (addr_ack_reg) begin
                            have_ptr_next = 1'b0;
                        end
                    end
                end
            end
            ST_TXB: begin
                if (scl_fall) begin
                    if (cnt_reg == LAST_BIT) begin
                        st_next = ST_RXACK;
                        oe_next = 1'b0;
                        ptr_next = ptr_reg + 8'h01;
                    end else begin
                        oe_next = ~shift_reg[6];
                        shift_next = {shift_reg[6:0], 1'b0};
                        cnt_next = cnt_reg + 3'h1;
                    end
                end
            end
            ST_RXACK: begin
                if (scl_rise & sda_in) begin
                    st_next = ST_IDLE;
                end else if (scl_fall) begin
                    st_next = ST_TXB;
                    cnt_next = 3'h0;
                    shift_next = rd_data;
                    oe_next = ~rd_data[7];
                end
            end
            ST_IDLE: begin
                oe_next = 1'b0;
            end
            default: begin
                st_next = ST_IDLE;
                oe_next = 1'b0;
            end
        endcase
        // Start and stop override whatever byte is in progress.
        if (bus_start) begin
            st_next = ST_ADDR;
            cnt_next = 3'h0;
            got_byte_next = 1'b0;
            oe_next = 1'b0;
        end else if (bus_stop) begin
            st_next = ST_IDLE;
            got_byte_next = 1'b0;
            oe_next = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Clocked state
    // ------------------------------------------------------------------
    // Serial port registers.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= ST_IDLE;
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            shift_reg <= ZERO_RESET;
            cnt_reg <= 3'h0;
            got_byte_reg <= 1'b0;
            ptr_reg <= ZERO_RESET;
            rw_reg <= 1'b0;
            have_ptr_reg <= 1'b0;
            addr_ack_reg <= 1'b0;
            oe_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            scl_q_reg <= scl_in;
            sda_q_reg <= sda_in;
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            got_byte_reg <= got_byte_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            have_ptr_reg <= have_ptr_next;
            addr_ack_reg <= addr_ack_next;
            oe_reg <= oe_next;
        end
    end

    // Status, masks and flags; status is resampled every cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_status_reg <= ZERO_RESET;
            lr_status_reg <= ZERO_RESET;
            top_live_reg <= ZERO_RESET;
            top_masks_reg <= TOP_MASKS_RESET; // [R8] [R10] [R11] [R12]
            top_flags_reg <= ZERO_RESET;
            sd_flags_reg <= ZERO_RESET;
            lr_flags_reg <= ZERO_RESET;
            irq_reg <= 1'b0;
        end else begin
            sd_status_reg <= sd_status_next; // [R16]
            lr_status_reg <= lr_status_next; // [R16]
            top_live_reg <= top_live_next; // [R9] [R14]
            top_masks_reg <= top_masks_next;
            top_flags_reg <= top_flags_next;
            sd_flags_reg <= sd_flags_next;
            lr_flags_reg <= lr_flags_next;
            irq_reg <= |top_flags_next;
        end
    end

    // Open drain: the line is only ever pulled low.
    assign sda_out = 1'b0 & oe_reg;
    assign sda_oe = oe_reg;
    assign irq_out = irq_reg;

endmodule : rstm_regs
`default_nettype wire

// ==== tb/rstm_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module rstm_host_model (
    input wire logic ref_clk,
    output var logic scl,
    output var logic sda_pull,
    input wire logic sda_line
);
    // One phase step, a third of a serial bit period, well above the two cycle minimum phase.
    localparam int HALF = 6;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic hp;
        repeat (HALF) @(negedge ref_clk);
    endtask : hp

    // Data moves only while the clock is low; start and stop are the
    // only places where the data line moves with the clock high.
    task automatic start_cond;
        sda_pull = 1'b0;
        hp();
        scl = 1'b1;
        hp();
        sda_pull = 1'b1;
        hp();
        scl = 1'b0;
    endtask : start_cond

    task automatic stop_cond;
        sda_pull = 1'b1;
        hp();
        scl = 1'b1;
        hp();
        sda_pull = 1'b0;
        hp();
    endtask : stop_cond

    task automatic bit_io(input logic b, output logic r);
        hp();
        sda_pull = !b;
        hp();
        scl = 1'b1;
        hp();
        r = sda_line;
        scl = 1'b0;
    endtask : bit_io

    // A released ninth bit serves as acknowledge poll and master NACK.
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
                           output logic nack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'b1, nack);
    endtask : byte_io

    task automatic access(input logic [6:0] addr, input logic [7:0] ptr,
                          input logic rd, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic nack);
        logic [7:0] dummy;
        logic n1;
        logic n2;
        logic n3;
        start_cond();
        byte_io({addr, 1'b0}, dummy, n1);
        byte_io(ptr, dummy, n2);
        if (rd) begin
            start_cond();
            byte_io({addr, 1'b1}, dummy, n3);
            // The last release is our own NACK, not the device's answer.
            byte_io(8'hff, rdata, dummy[0]);
        end else begin
            byte_io(wdata, dummy, n3);
        end
        stop_cond();
        nack = n1 | n2 | n3;
    endtask : access
endmodule : rstm_host_model
`default_nettype wire

// ==== tb/rstm_regs_properties.sv ====
`timescale 1ns/100ps
`default_nettype none
module rstm_regs_properties (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic power_ok_pin,
    input wire logic ext_sync_clock_invalid,
    input wire logic thermal_warn_in,
    input wire logic load_meas_ready,
    input wire logic irq_out
);
    logic [3:0] evt_hist;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // Recent top level events; an interrupt may only rise after one.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_hist <= 4'h0;
        end else begin
            evt_hist <= {evt_hist[2:0], load_meas_ready |
                $changed(power_ok_pin) | $rose(ext_sync_clock_invalid) |
                $rose(thermal_warn_in)};
        end
    end

    // ------------------------------------------------------------------
    // Serial port and interrupt line
    // ------------------------------------------------------------------
    a_sda_drive_zero: assert property (sda_out == 1'b0)
        else $error("sda drive value not zero");
    a_reset_quiet: assert property ($rose(rst_n) |->
        !sda_oe && !irq_out)
        else $error("outputs active right after reset");
    a_oe_on_low: assert property ($changed(sda_oe) |->
        !scl_in && !$past(scl_in))
        else $error("sda enable changed outside clock low");
    a_oe_high_stable: assert property ($rose(scl_in) |->
        $stable(sda_oe) [*3])
        else $error("sda enable moved while clock high");
    a_oe_stands: assert property ($rose(sda_oe) |-> sda_oe [*4])
        else $error("sda drive too short");
    a_irq_has_cause: assert property ($rose(irq_out) |-> |evt_hist)
        else $error("interrupt without a source event");
    a_irq_clear_bus: assert property ($fell(irq_out) |->
        !$past(scl_in) && $past(scl_in, 2))
        else $error("interrupt dropped outside a write");
    a_stop_no_drive: assert property (scl_in && $past(scl_in) &&
        $rose(sda_in) |=> !sda_oe)
        else $error("sda driven after stop");
endmodule : rstm_regs_properties

bind rstm_regs rstm_regs_properties u_props (.ref_clk, .rst_n, .scl_in,
    .sda_in, .sda_out, .sda_oe, .power_ok_pin, .ext_sync_clock_invalid,
    .thermal_warn_in, .load_meas_ready, .irq_out);
`default_nettype wire

// ==== tb/test_regulator_status_and_top_mask_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin \
    mismatches++; $display("wrong value %s expected %h seen %h", nm, exp, \
    got); end end
module test_regulator_status_and_top_mask_regs;
    import rstm_pkg::*;
    logic ref_clk, rst_n, scl, sda_pull, sda_wire, sda_oe, sda_out, irq_out;
    logic power_ok_pin, ext_sync, thermal, meas, nack;
    logic [5:0] sd; // on1, inv1, lim1, on0, inv0, lim0.
    logic [5:0] lr;
    logic [7:0] rdat;
    int mismatches = 0;
    int checked = 0;
    int pos[6] = '{7, 6, 4, 3, 2, 0};

    // Open drain line with a pull-up: low if either side pulls.
    assign sda_wire = ~(sda_pull | (sda_oe & ~sda_out));

    rstm_host_model u_host (.ref_clk(ref_clk), .scl(scl),
        .sda_pull(sda_pull), .sda_line(sda_wire));
    rstm_regs u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
        .stepdown1_on(sd[5]), .stepdown1_vout_invalid(sd[4]),
        .stepdown1_limit_active(sd[3]), .stepdown0_on(sd[2]),
        .stepdown0_vout_invalid(sd[1]), .stepdown0_limit_active(sd[0]),
        .linreg1_on(lr[5]), .linreg1_vout_invalid(lr[4]),
        .linreg1_limit_active(lr[3]), .linreg0_on(lr[2]),
        .linreg0_vout_invalid(lr[1]), .linreg0_limit_active(lr[0]),
        .power_ok_pin(power_ok_pin), .ext_sync_clock_invalid(ext_sync),
        .thermal_warn_in(thermal), .load_meas_ready(meas),
        .irq_out(irq_out));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        u_host.access(DEV_ADDR_DEFAULT, p, 1'b0, d, rdat, nack);
        `CHK("write ack", 1'b0, nack)
    endtask : wr

    task automatic rd(input string nm, input logic [7:0] p,
                      input logic [7:0] exp);
        u_host.access(DEV_ADDR_DEFAULT, p, 1'b1, 8'h00, rdat, nack);
        `CHK(nm, exp, rdat)
    endtask : rd

    task automatic settle;
        repeat (3) @(negedge ref_clk);
    endtask : settle

    task automatic results;
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results

    // A hung access still reaches the verdict.
    initial begin
        repeat (100000) @(posedge ref_clk);
        mismatches++;
        results();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_n, sd, lr, power_ok_pin, ext_sync, thermal, meas} = '0;
        repeat (10) @(negedge ref_clk);
        rst_n = 1'b1;
        settle();
        rd("mask reset", OFS_TOP_MASKS, 8'h90);
        rd("sd idle", OFS_SD_STATUS, 8'h00);
        {power_ok_pin, ext_sync, thermal} = 3'h7;
        settle();
        `CHK("irq thermal", 1'b1, irq_out)
        rd("flags default", OFS_TOP_FLAGS, 8'h04);
        rd("live", OFS_TOP_LIVE, 8'h94);
        wr(OFS_TOP_FLAGS, 8'h04);
        settle();
        `CHK("irq cleared", 1'b0, irq_out)
        wr(OFS_TOP_MASKS, 8'hff);
        rd("mask stored", OFS_TOP_MASKS, 8'h95);
        thermal = 1'b0;
        meas = 1'b1;
        @(negedge ref_clk);
        {thermal, meas} = 2'b10;
        settle();
        `CHK("irq masked", 1'b0, irq_out)
        rd("flags masked", OFS_TOP_FLAGS, 8'h00);
        rd("live masked", OFS_TOP_LIVE, 8'h94);
        wr(OFS_TOP_MASKS, 8'h00);
        meas = 1'b1;
        @(negedge ref_clk);
        meas = 1'b0;
        settle();
        `CHK("irq meas", 1'b1, irq_out)
        rd("meas flag", OFS_TOP_FLAGS, 8'h01);
        wr(OFS_TOP_FLAGS, 8'h01);
        for (int i = 0; i < 6; i++) begin
            sd = 6'h20 >> i;
            lr = sd;
            settle();
            rd("sd bit", OFS_SD_STATUS, 8'h01 << pos[i]);
            rd("lr bit", OFS_LR_STATUS, 8'h01 << pos[i]);
        end
        {sd, lr} = '1;
        settle();
        wr(OFS_SD_STATUS, 8'h00);
        rd("sd all", OFS_SD_STATUS, 8'hdd);
        rd("sd again", OFS_SD_STATUS, 8'hdd);
        rd("lr all", OFS_LR_STATUS, 8'hdd);
        sd = 6'h00;
        settle();
        wr(OFS_SD_FLAGS, 8'hff);
        sd[3] = 1'b1;
        settle();
        rd("rail flag", OFS_SD_FLAGS, 8'h10);
        wr(OFS_SD_FLAGS, 8'h10);
        rd("rail clear", OFS_SD_FLAGS, 8'h00);
        // A validity flag must also latch when the rail becomes valid again.
        sd[1] = 1'b1;
        settle();
        wr(OFS_SD_FLAGS, 8'h04);
        sd[1] = 1'b0;
        settle();
        rd("inv fall flag", OFS_SD_FLAGS, 8'h04);
        rd("unmapped", 8'h30, 8'h00);
        u_host.access(DEV_ADDR_DEFAULT ^ 7'h01, OFS_TOP_MASKS, 1'b0,
                      8'h00, rdat, nack);
        `CHK("foreign addr", 1'b1, nack)
        rd("mask kept", OFS_TOP_MASKS, 8'h00);
        // Unmasked power-good change and sync-invalid rise both flag.
        power_ok_pin = 1'b0;
        ext_sync = 1'b0;
        settle();
        ext_sync = 1'b1;
        settle();
        `CHK("irq pok sync", 1'b1, irq_out)
        rd("pok sync flags", OFS_TOP_FLAGS, 8'h90);
        results();
    end
endmodule : test_regulator_status_and_top_mask_regs
`default_nettype wire
